// [src/serial_bus_control_defines.vh]
// Constants for the serial bus control block: addresses, field positions, reset values and counts.
// Contract
// - A system reset clears every bit of the bus control register to 00h.
// - The processor may write the bus control register as a whole byte or one bit at a time without touching the other bits.
// - Writing 1 to the bus-free trigger forces the serial output latch to 1 to send a bus release.
// - The bus-free trigger returns to 0 by itself once the output latch has been set.
// - Writing 1 to the command trigger forces the serial output latch to 0 to send a command.
// - The command trigger returns to 0 by itself once the output latch has been cleared.
// - While the channel enable bit is 0, both trigger bits are held at 0.
// - The bus-free detected flag is set when the receive logic sees a bus release on the bus.
// - The bus-free detected flag is cleared when the address after a release does not match the own slave address, and while the channel is disabled.
// - The bus-free detected flag is read-only, so writes to its bit leave it unchanged.
// - The bus-free trigger and command trigger bits read back as 0.
// - The channel enable bit is bit 7 of the serial mode register, not a bit of the bus control register.
`ifndef SERIAL_BUS_CONTROL_DEFINES_VH
`define SERIAL_BUS_CONTROL_DEFINES_VH

`define SERIAL_MODE_ADDR 16'hff60
`define SERIAL_BUS_CONTROL_ADDR 16'hff61

`define SERIAL_MODE_RESET 8'h00
`define SERIAL_BUS_CONTROL_RESET 8'h00

`define MODE_CHANNEL_ENABLE_BIT 7
`define MODE_ADDR_MATCH_BIT 6

`define CTRL_BUS_FREE_TRIGGER_BIT 0
`define CTRL_COMMAND_TRIGGER_BIT 1
`define CTRL_BUS_FREE_DETECTED_BIT 2
`define CTRL_PLAIN_STORE_MASK 8'ha0

`define ADDR_BITS_LAST 3'h7

`endif

// [src/link_sampler.v]
// Two-stage synchroniser for the serial bus pins, with edge detection behind the second stage.
`timescale 1ns/1ps
`default_nettype none

module link_sampler #(
   parameter W = 2
) (
   input wire sys_clk,
   input wire rst_n,
   input wire [W-1:0] pin_in,
   output wire [W-1:0] level,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);

   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   reg [W-1:0] last_reg;

   // Pins idle high on an open-drain bus, so reset to the idle level to avoid a false edge.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_reg <= {W{1'b1}};
         sync_reg <= {W{1'b1}};
         last_reg <= {W{1'b1}};
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise = sync_reg & ~last_reg;
   assign fall = ~sync_reg & last_reg;

endmodule

`default_nettype wire

// [src/serial_bus_control.v]
// Serial bus control register with release and command triggers, serial output latch and release detection.
`timescale 1ns/1ps
`default_nettype none
`include "serial_bus_control_defines.vh"

module serial_bus_control (
   input wire sys_clk,
   input wire rst_n,
   input wire [15:0] cpu_addr,
   input wire cpu_wr_byte,
   input wire cpu_wr_bit,
   input wire [2:0] cpu_bit_sel,
   input wire cpu_bit_val,
   input wire [7:0] cpu_wdata,
   input wire cpu_rd,
   input wire [7:0] own_slave_address,
   input wire sclk_pin,
   input wire sdata_pin,
   input wire shift_load,
   input wire shift_bit,
   output reg [7:0] cpu_rdata,
   output reg so_latch,
   output reg channel_enable,
   output reg bus_free_detected,
   output reg address_match
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT_CMD = 2'h1;
   localparam ST_ADDR = 2'h2;

   wire [1:0] pin_level;
   wire [1:0] pin_rise;
   wire [1:0] pin_fall;
   wire sclk_high;
   wire sclk_rise;
   wire bus_free_seen;
   wire command_seen;

   reg [7:0] wr_mask;
   reg [7:0] wr_val;
   wire mode_sel;
   wire ctrl_sel;
   wire [7:0] mode_mask;
   wire [7:0] ctrl_mask;

   reg [5:0] mode_store_reg;
   reg [7:0] ctrl_store_reg;
   reg bus_free_trigger_reg;
   reg command_trigger_reg;
   reg [1:0] rx_state_reg;
   reg [1:0] rx_state_next;
   reg [2:0] bit_cnt_reg;
   reg [6:0] addr_shift_reg;
   wire [7:0] addr_word;
   wire addr_done;
   wire addr_mismatch;
   reg [7:0] read_value;

   link_sampler #(
      .W(2)
   ) u_link_sampler (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .pin_in({sdata_pin, sclk_pin}),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   assign sclk_high = pin_level[0];
   assign sclk_rise = pin_rise[0];
   // A data edge while the serial clock stays high marks a release (rising) or a command (falling).
   assign bus_free_seen = pin_rise[1] & sclk_high & ~pin_rise[0] & ~pin_fall[0];
   assign command_seen = pin_fall[1] & sclk_high & ~pin_rise[0] & ~pin_fall[0];

   // A byte write touches all bits, a bit write only the selected one.
   always @* begin
      if (cpu_wr_byte) begin
         wr_mask = 8'hff;
         wr_val = cpu_wdata;
      end else if (cpu_wr_bit) begin
         wr_mask = 8'h01 << cpu_bit_sel;
         wr_val = {8{cpu_bit_val}};
      end else begin
         wr_mask = 8'h00;
         wr_val = 8'h00;
      end
   end

   assign mode_sel = (cpu_addr == `SERIAL_MODE_ADDR);
   assign ctrl_sel = (cpu_addr == `SERIAL_BUS_CONTROL_ADDR);
   assign mode_mask = mode_sel ? wr_mask : 8'h00;
   assign ctrl_mask = ctrl_sel ? wr_mask : 8'h00;

   // Mode register: bit 7 enables the channel, bit 6 is the read-only match flag, the rest are plain storage.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         channel_enable <= 1'b0;
         mode_store_reg <= 6'h00;
      end else begin
         if (mode_mask[`MODE_CHANNEL_ENABLE_BIT]) begin
            channel_enable <= wr_val[`MODE_CHANNEL_ENABLE_BIT];
         end
         mode_store_reg <= (mode_store_reg & ~mode_mask[5:0]) | (wr_val[5:0] & mode_mask[5:0]);
      end
   end

   // Only bits 7 and 5 of the control register are kept as plain storage here.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_store_reg <= `SERIAL_BUS_CONTROL_RESET;
      end else begin
         ctrl_store_reg <= ((ctrl_store_reg & ~ctrl_mask) | (wr_val & ctrl_mask)) & `CTRL_PLAIN_STORE_MASK;
      end
   end

   // Triggers live one cycle: set by the write, cleared at the edge that moves the output latch.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         bus_free_trigger_reg <= 1'b0;
         command_trigger_reg <= 1'b0;
      end else if (!channel_enable) begin
         bus_free_trigger_reg <= 1'b0;
         command_trigger_reg <= 1'b0;
      end else begin
         if (ctrl_mask[`CTRL_BUS_FREE_TRIGGER_BIT] && wr_val[`CTRL_BUS_FREE_TRIGGER_BIT]) begin
            bus_free_trigger_reg <= 1'b1;
         end else begin
            bus_free_trigger_reg <= 1'b0;
         end
         if (ctrl_mask[`CTRL_COMMAND_TRIGGER_BIT] && wr_val[`CTRL_COMMAND_TRIGGER_BIT]) begin
            command_trigger_reg <= 1'b1;
         end else begin
            command_trigger_reg <= 1'b0;
         end
      end
   end

   // Serial output latch: the triggers override the shift logic; a release wins if both are pending.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         so_latch <= 1'b1;
      end else if (bus_free_trigger_reg) begin
         so_latch <= 1'b1;
      end else if (command_trigger_reg) begin
         so_latch <= 1'b0;
      end else if (shift_load) begin
         so_latch <= shift_bit;
      end
   end

   // Receive tracker: after a release, wait for a command, then gather the eight address bits.
   assign addr_word = {addr_shift_reg, pin_level[1]};
   assign addr_done = (rx_state_reg == ST_ADDR) && sclk_rise && (bit_cnt_reg == `ADDR_BITS_LAST);
   assign addr_mismatch = addr_done && (addr_word != own_slave_address);

   always @* begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         ST_IDLE: begin
            if (bus_free_seen) begin
               rx_state_next = ST_WAIT_CMD;
            end
         end
         ST_WAIT_CMD: begin
            if (command_seen) begin
               rx_state_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            if (bus_free_seen) begin
               rx_state_next = ST_WAIT_CMD;
            end else if (addr_done) begin
               rx_state_next = ST_IDLE;
            end
         end
         default: begin
            rx_state_next = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rst_n || !channel_enable) begin
         rx_state_reg <= ST_IDLE;
         bit_cnt_reg <= 3'h0;
         addr_shift_reg <= 7'h00;
      end else begin
         rx_state_reg <= rx_state_next;
         if (rx_state_reg != ST_ADDR || bus_free_seen) begin
            bit_cnt_reg <= 3'h0;
         end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            addr_shift_reg <= addr_word[6:0];
         end
      end
   end

   // Detected flag: a new release wins over a mismatch clear in the same cycle; disable clears it.
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         bus_free_detected <= 1'b0;
      end else if (!channel_enable) begin
         bus_free_detected <= 1'b0;
      end else if (bus_free_seen) begin
         bus_free_detected <= 1'b1;
      end else if (addr_mismatch) begin
         bus_free_detected <= 1'b0;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n || !channel_enable) begin
         address_match <= 1'b0;
      end else if (bus_free_seen) begin
         address_match <= 1'b0;
      end else if (addr_done) begin
         address_match <= (addr_word == own_slave_address);
      end
   end

   // Read data is registered; trigger bits always read as 0 and unmapped addresses read as 00h.
   always @* begin
      read_value = 8'h00;
      if (mode_sel) begin
         read_value = {channel_enable, address_match, mode_store_reg};
      end else if (ctrl_sel) begin
         read_value = ctrl_store_reg;
         read_value[`CTRL_BUS_FREE_DETECTED_BIT] = bus_free_detected;
         read_value[`CTRL_BUS_FREE_TRIGGER_BIT] = 1'b0;
         read_value[`CTRL_COMMAND_TRIGGER_BIT] = 1'b0;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_rd) begin
         cpu_rdata <= read_value;
      end
   end

endmodule

`default_nettype wire

// [tb/sbc_assertions.sv]
// Checker for the serial bus control register and its release detection.
`timescale 1ns/1ps
`default_nettype none
module sbc_assertions (
   input wire sys_clk,
   input wire rst_n,
   input wire [15:0] cpu_addr,
   input wire cpu_wr_byte,
   input wire cpu_wr_bit,
   input wire [2:0] cpu_bit_sel,
   input wire cpu_bit_val,
   input wire [7:0] cpu_wdata,
   input wire cpu_rd,
   input wire sclk_pin,
   input wire sdata_pin,
   input wire shift_load,
   input wire [7:0] cpu_rdata,
   input wire so_latch,
   input wire channel_enable,
   input wire bus_free_detected
);
   wire w61 = cpu_wr_byte && cpu_addr == 16'hff61;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   AST_RST_CLR: assert property (disable iff (1'b0)
      !rst_n |=> so_latch && !channel_enable && !bus_free_detected && cpu_rdata == 8'h00)
      else $error("reset values wrong");
   AST_REL_SET: assert property (
      w61 && cpu_wdata[0] && channel_enable ##1 channel_enable |=> so_latch)
      else $error("release trigger missed");
   AST_CMD_CLR: assert property (
      w61 && cpu_wdata[1:0] == 2'b10 && channel_enable ##1 channel_enable && !shift_load |=> !so_latch)
      else $error("command trigger missed");
   AST_TRIG_DIS: assert property (
      w61 && !channel_enable ##1 !channel_enable && !shift_load |=> $stable(so_latch))
      else $error("trigger acted while disabled");
   AST_DET_LAT: assert property (
      $rose(sdata_pin) && sclk_pin && channel_enable |-> ##[2:5] bus_free_detected)
      else $error("release not detected");
   AST_DIS_NODET: assert property (!channel_enable |=> !bus_free_detected)
      else $error("detected flag set while disabled");
   AST_RD_CTRL: assert property (
      cpu_rd && cpu_addr == 16'hff61 |=> cpu_rdata[1:0] == 2'b00 && cpu_rdata[2] == $past(bus_free_detected))
      else $error("control readback wrong");
   AST_ENB_BYTE: assert property (
      cpu_wr_byte && cpu_addr == 16'hff60 |=> channel_enable == $past(cpu_wdata[7]))
      else $error("enable not taken from byte write");
   AST_CTRL_BIT_CMD: assert property (
      cpu_wr_bit && !cpu_wr_byte && cpu_addr == 16'hff61 && cpu_bit_sel == 3'h1 && cpu_bit_val && channel_enable
      ##1 channel_enable && !shift_load |=> !so_latch)
      else $error("control bit write command missed");
   AST_BIT_WR: assert property (
      cpu_wr_bit && !cpu_wr_byte && cpu_addr == 16'hff60 && cpu_bit_sel == 3'h7
      |=> channel_enable == $past(cpu_bit_val))
      else $error("bit write not applied");
   cover property (w61 && cpu_wdata[0] && channel_enable);
   cover property ($fell(bus_free_detected) && channel_enable);
   cover property (cpu_wr_bit && cpu_addr == 16'hff60);
endmodule
`default_nettype wire

// [tb/bus_peer.sv]
// Peer master that sends a release, a command and an address byte.
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
   output var logic sclk_pin,
   output var logic sdata_pin
);
   initial begin
      sclk_pin = 1'b1;
      sdata_pin = 1'b1;
   end
   // The clock stands high between frames and the data line ends released high.
   task automatic frame(input logic [7:0] a);
      sdata_pin = 1'b0;
      #64 sdata_pin = 1'b1;
      #64 sdata_pin = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #32 sclk_pin = 1'b0;
         sdata_pin = a[i];
         #32 sclk_pin = 1'b1;
      end
      #32 sclk_pin = 1'b0;
      sdata_pin = 1'b1;
      #32 sclk_pin = 1'b1;
      #64;
   endtask
endmodule
`default_nettype wire

// [tb/serial_bus_control_test.sv]
// Self-checking bench for the serial bus control register.
`timescale 1ns/1ps
`default_nettype none
module serial_bus_control_test;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] cpu_addr = 16'h0000;
   logic cpu_wr_byte = 1'b0;
   logic cpu_wr_bit = 1'b0;
   logic cpu_rd = 1'b0;
   logic [7:0] cpu_wdata = 8'h00;
   logic [7:0] q;
   wire sclk_pin, sdata_pin, so_latch, channel_enable, bus_free_detected, address_match;
   wire [7:0] cpu_rdata;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] rows [5] = '{32'hff60_80_80, 32'hff61_ff_a0, 32'hff61_00_00, 32'hff62_55_00, 32'hff60_ff_bf};
   always #2 sys_clk = ~sys_clk;
   serial_bus_control i_serial_bus_control (
      .sys_clk(sys_clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr_byte(cpu_wr_byte),
      .cpu_wr_bit(cpu_wr_bit), .cpu_bit_sel(cpu_wdata[6:4]), .cpu_bit_val(cpu_wdata[0]),
      .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .own_slave_address(8'h5a), .sclk_pin(sclk_pin),
      .sdata_pin(sdata_pin), .shift_load(1'b0), .shift_bit(1'b0), .cpu_rdata(cpu_rdata),
      .so_latch(so_latch), .channel_enable(channel_enable), .bus_free_detected(bus_free_detected),
      .address_match(address_match));
   bus_peer i_bus_peer (.sclk_pin(sclk_pin), .sdata_pin(sdata_pin));
   task chk(input logic [7:0] s, input logic [7:0] e, input string n);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d, input logic b);
      @(negedge sys_clk);
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr_byte = !b;
      cpu_wr_bit = b;
      @(negedge sys_clk);
      cpu_wr_byte = 1'b0;
      cpu_wr_bit = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask
   task rd(input logic [15:0] a);
      @(negedge sys_clk);
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(negedge sys_clk);
      cpu_rd = 1'b0;
      @(negedge sys_clk);
      q = cpu_rdata;
   endtask
   task close_out();
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge sys_clk);
      chk({5'h00, so_latch, channel_enable, bus_free_detected}, 8'h04, "reset pins");
      rst_n = 1'b1;
      rd(16'hff61);
      chk(q, 8'h00, "control after reset");
      foreach (rows[i]) begin
         wr(rows[i][31:16], rows[i][15:8], 1'b0);
         rd(rows[i][31:16]);
         chk(q, rows[i][7:0], "row readback");
      end
      wr(16'hff61, 8'h02, 1'b0);
      chk({7'h00, so_latch}, 8'h00, "command latch");
      rd(16'hff61);
      chk(q, 8'h00, "trigger readback");
      wr(16'hff61, 8'h01, 1'b0);
      chk({7'h00, so_latch}, 8'h01, "release latch");
      i_bus_peer.frame(8'ha5);
      chk({7'h00, bus_free_detected}, 8'h00, "mismatch clears");
      i_bus_peer.frame(8'h5a);
      chk({6'h00, address_match, bus_free_detected}, 8'h03, "match keeps");
      wr(16'hff61, 8'h00, 1'b0);
      rd(16'hff61);
      chk(q, 8'h04, "detected read-only");
      wr(16'hff61, 8'h11, 1'b1);
      chk({7'h00, so_latch}, 8'h00, "bit write command");
      wr(16'hff60, 8'h70, 1'b1);
      chk({6'h00, channel_enable, bus_free_detected}, 8'h00, "disable clears");
      wr(16'hff61, 8'h01, 1'b0);
      chk({7'h00, so_latch}, 8'h00, "triggers held off");
      wr(16'hff61, 8'ha0, 1'b0);
      rd(16'hff61);
      chk(q, 8'ha0, "store while disabled");
      rst_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      chk({7'h00, so_latch}, 8'h01, "latch after second reset");
      rd(16'hff61);
      chk(q, 8'h00, "control after second reset");
      close_out();
   end
   // The run needs about 1.9 us; the limit leaves ample slack.
   initial begin
      #20000;
      n_mismatch++;
      close_out();
   end
endmodule
bind serial_bus_control sbc_assertions i_sbc_assertions (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .cpu_addr(cpu_addr),
   .cpu_wr_byte(cpu_wr_byte),
   .cpu_wr_bit(cpu_wr_bit),
   .cpu_bit_sel(cpu_bit_sel),
   .cpu_bit_val(cpu_bit_val),
   .cpu_wdata(cpu_wdata),
   .cpu_rd(cpu_rd),
   .sclk_pin(sclk_pin),
   .sdata_pin(sdata_pin),
   .shift_load(shift_load),
   .cpu_rdata(cpu_rdata),
   .so_latch(so_latch),
   .channel_enable(channel_enable),
   .bus_free_detected(bus_free_detected)
);
`default_nettype wire
